// [shared/mpd_pkg.sv]
// Purpose: constants for the message priority display arbiter
// Assumes: AHB-Lite register access, 20 MHz system clock
// Notes: config word layout is shared by software and the arbiter
`default_nettype none
package mpd_pkg;
	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int MAX_MSGS = 50;
	localparam int IDX_W = 6;
	localparam int PRIO_W = 7;
	localparam int LINES = 6;
	localparam int IRQ_W = 3;
	localparam int IVL_W = 16;
	// ----------------------------------------
	// timing: scroll interval counts in milliseconds
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_BASE_NS = 1000000;
	localparam int TICK_BASE_CYC = TICK_BASE_NS / CLK_PERIOD_NS;
	localparam logic [3:0] HALF_MULT = 4'hA;
	localparam logic [IVL_W-1:0] IVL_RST = 16'h0064;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_IRQ_STAT = 12'h008;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h00C;
	localparam logic [11:0] OFS_IVL = 12'h010;
	localparam logic [11:0] OFS_ACT_LO = 12'h014;
	localparam logic [11:0] OFS_ACT_HI = 12'h018;
	localparam logic [11:0] OFS_CFG = 12'h100;
	// ----------------------------------------
	// control and irq bits
	// ----------------------------------------
	localparam int CTRL_RUN = 0;
	localparam int CTRL_CS = 1;
	localparam int STAT_VALID = 8;
	localparam int IRQ_ACT = 0;
	localparam int IRQ_SHOWN = 1;
	localparam int IRQ_ACK = 2;
	// ----------------------------------------
	// per-instance config word
	// ----------------------------------------
	localparam int CFG_W = 19;
	localparam int CFG_PRIO = 0;
	localparam int CFG_ACK = 7;
	localparam int CFG_BUILTIN = 8;
	localparam int CFG_EXTERN = 9;
	localparam int CFG_CS = 10;
	localparam int CFG_STYLE = 11;
	localparam int CFG_LINE = 12;
	localparam int CFG_WEB = 18;
	localparam logic [CFG_W-1:0] CFG_RST = 19'h00300;
endpackage
`default_nettype wire

// [rtl/mpd_arbiter.sv]
// Purpose: message priority display arbiter with AHB-Lite registers
// Assumes: enables and keys are asynchronous pins, one 20 MHz clock
// Notes: text rendering lives downstream; this block picks what to show
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module mpd_arbiter #(
	parameter int NUM_MSGS = mpd_pkg::MAX_MSGS,
	parameter int TICK_CYCLES = mpd_pkg::TICK_BASE_CYC
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// message enables and instance outputs
	input wire logic [NUM_MSGS-1:0] msg_enable_i,
	output logic [NUM_MSGS-1:0] msg_active_o,
	// operator keys
	input wire logic confirm_key_i,
	input wire logic up_key_i,
	input wire logic down_key_i,
	// display selection
	output logic shown_valid_o,
	output logic [mpd_pkg::IDX_W-1:0] shown_index_o,
	output logic builtin_display_target_o,
	output logic external_panel_target_o,
	output logic web_show_o,
	output logic scroll_style_o,
	output logic [mpd_pkg::LINES-1:0] line_scroll_enable_o,
	output logic char_step_o,
	output logic half_select_o,
	// interrupt
	output logic irq_o
);
	// ----------------------------------------
	// parameter checks
	// ----------------------------------------
	// refused at elaboration so a bad build never reaches simulation
	if (NUM_MSGS < 1 || NUM_MSGS > mpd_pkg::MAX_MSGS) begin : g_bad_n
		$error("NUM_MSGS out of range");
	end
	// base counter is 16 bits wide
	if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
		$error("TICK_CYCLES out of range");
	end

	localparam int N = NUM_MSGS;
	localparam int IW = mpd_pkg::IDX_W;
	localparam int CW = mpd_pkg::CFG_W;
	localparam int PW = mpd_pkg::PRIO_W;
	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic run;
		logic cs_flag;
		logic [mpd_pkg::IRQ_W-1:0] irq_stat;
		logic [mpd_pkg::IRQ_W-1:0] irq_mask;
		logic [mpd_pkg::IVL_W-1:0] ivl;
		logic [N-1:0][CW-1:0] cfg;
		logic [N-1:0] en_s1;
		logic [N-1:0] en_s2;
		logic [N-1:0] en_d;
		logic [N-1:0] active;
		logic [2:0] key_s1;
		logic [2:0] key_s2;
		logic [2:0] key_d;
		logic shown_v;
		logic [IW-1:0] shown;
		logic [15:0] base_cnt;
		logic [mpd_pkg::IVL_W-1:0] ivl_cnt;
		logic [3:0] ten_cnt;
		logic step;
		logic half;
		logic wr_pend;
		logic [11:0] wr_addr;
		logic [31:0] rdata;
	} mpd_state_type;

	mpd_state_type s_r;
	mpd_state_type s_nxt;

	logic [N-1:0] rise;
	logic [N-1:0] elig;
	logic [2:0] key_hit;
	logic ack_clr;
	logic best_v;
	logic new_v;
	logic old_v;
	logic first_v;
	logic nxt_v;
	logic prv_v;
	logic still;
	logic [IW-1:0] best;
	logic [IW-1:0] new_i;
	logic [IW-1:0] first;
	logic [IW-1:0] last;
	logic [IW-1:0] nxt;
	logic [IW-1:0] prv;
	logic [PW-1:0] best_p;
	logic [PW-1:0] new_p;
	logic [PW-1:0] old_p;
	logic [PW-1:0] p;
	logic [CW-1:0] sc;
	logic [63:0] act64;
	logic [11:0] a;
	logic [11:0] wa;
	logic [31:0] rd;
	logic [IW-1:0] ci;

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		// enables and keys pass two flops before any logic sees them
		s_nxt.en_s1 = msg_enable_i;
		s_nxt.en_s2 = s_r.en_s1;
		s_nxt.en_d = s_r.en_s2;
		s_nxt.key_s1 = {down_key_i, up_key_i, confirm_key_i};
		s_nxt.key_s2 = s_r.key_s1;
		s_nxt.key_d = s_r.key_s2;
		rise = s_r.en_s2 & ~s_r.en_d;
		key_hit = s_r.key_s2 & ~s_r.key_d;
		sc = s_r.cfg[s_r.shown];

		// confirm only counts on a shown, ack-type, already-dropped message
		ack_clr = key_hit[0] && s_r.shown_v && sc[mpd_pkg::CFG_ACK]
			&& !s_r.en_s2[s_r.shown];

		// activation and clearing per instance
		for (int i = 0; i < N; i++) begin
			if (rise[i]) begin
				s_nxt.active[i] = 1'b1;
			end else if (!s_r.en_s2[i] && s_r.en_d[i]
				&& !s_r.cfg[i][mpd_pkg::CFG_ACK]) begin
				s_nxt.active[i] = 1'b0;
			end else if (ack_clr && s_r.shown == IW'(i)) begin
				s_nxt.active[i] = 1'b0;
			end
		end

		// eligibility follows the charset flag and run mode
		for (int i = 0; i < N; i++) begin
			elig[i] = s_nxt.active[i] && s_r.run
				&& (s_r.cfg[i][mpd_pkg::CFG_CS] == s_r.cs_flag);
		end

		// priority search; lowest index wins a tie
		best_v = 1'b0;
		new_v = 1'b0;
		old_v = 1'b0;
		first_v = 1'b0;
		nxt_v = 1'b0;
		prv_v = 1'b0;
		best = '0;
		new_i = '0;
		first = '0;
		last = '0;
		nxt = '0;
		prv = '0;
		best_p = '0;
		new_p = '0;
		old_p = '0;
		for (int i = 0; i < N; i++) begin
			p = s_r.cfg[i][mpd_pkg::CFG_PRIO +: PW];
			if (elig[i]) begin
				if (!best_v || p > best_p) begin
					best_v = 1'b1;
					best = IW'(i);
					best_p = p;
				end
				if (rise[i] && (!new_v || p > new_p)) begin
					new_v = 1'b1;
					new_i = IW'(i);
					new_p = p;
				end
				if (!rise[i] && (!old_v || p > old_p)) begin
					old_v = 1'b1;
					old_p = p;
				end
				if (!first_v) begin
					first_v = 1'b1;
					first = IW'(i);
				end
				if (!nxt_v && IW'(i) > s_r.shown) begin
					nxt_v = 1'b1;
					nxt = IW'(i);
				end
				if (IW'(i) < s_r.shown) begin
					prv_v = 1'b1;
					prv = IW'(i);
				end
				last = IW'(i);
			end
		end
		if (!nxt_v) begin
			nxt = first; // wrap to the lowest index
		end
		if (!prv_v) begin
			prv = last; // wrap to the highest index
		end

		// choice of the shown message
		still = s_r.shown_v && elig[s_r.shown];
		if (!s_r.run) begin
			s_nxt.shown_v = 1'b0;
		end else if (new_v && (!old_v || new_p > old_p)) begin
			s_nxt.shown_v = 1'b1;
			s_nxt.shown = new_i;
		end else if (!still) begin
			s_nxt.shown_v = best_v;
			s_nxt.shown = best_v ? best : s_r.shown;
		end else if (key_hit[1]) begin
			s_nxt.shown = nxt;
		end else if (key_hit[2]) begin
			s_nxt.shown = prv;
		end

		// scroll timing restarts whenever a new message comes up
		s_nxt.step = 1'b0;
		if (s_nxt.shown != s_r.shown || s_nxt.shown_v != s_r.shown_v) begin
			s_nxt.base_cnt = '0;
			s_nxt.ivl_cnt = '0;
			s_nxt.ten_cnt = '0;
			s_nxt.half = 1'b0;
		end else if (s_r.base_cnt == TICK_LAST) begin
			s_nxt.base_cnt = '0;
			// a zero interval behaves as one unit rather than stalling
			if (s_r.ivl_cnt + 16'h0001 >= s_r.ivl) begin
				s_nxt.ivl_cnt = '0;
				s_nxt.step = 1'b1;
				if (s_r.ten_cnt == mpd_pkg::HALF_MULT - 4'h1) begin
					s_nxt.ten_cnt = '0;
					s_nxt.half = !s_r.half;
				end else begin
					s_nxt.ten_cnt = s_r.ten_cnt + 4'h1;
				end
			end else begin
				s_nxt.ivl_cnt = s_r.ivl_cnt + 16'h0001;
			end
		end else begin
			s_nxt.base_cnt = s_r.base_cnt + 16'h0001;
		end

		// interrupt status: software clear first so a new event wins
		wa = s_r.wr_addr;
		if (s_r.wr_pend && wa == mpd_pkg::OFS_IRQ_STAT) begin
			s_nxt.irq_stat = s_r.irq_stat & ~hwdata_i[mpd_pkg::IRQ_W-1:0];
		end
		if (|rise) begin
			s_nxt.irq_stat[mpd_pkg::IRQ_ACT] = 1'b1;
		end
		if (s_nxt.shown != s_r.shown || s_nxt.shown_v != s_r.shown_v) begin
			s_nxt.irq_stat[mpd_pkg::IRQ_SHOWN] = 1'b1;
		end
		if (ack_clr) begin
			s_nxt.irq_stat[mpd_pkg::IRQ_ACK] = 1'b1;
		end

		// register writes land in the data phase
		ci = IW'((wa - mpd_pkg::OFS_CFG) >> 2);
		if (s_r.wr_pend) begin
			if (wa == mpd_pkg::OFS_CTRL) begin
				s_nxt.run = hwdata_i[mpd_pkg::CTRL_RUN];
				s_nxt.cs_flag = hwdata_i[mpd_pkg::CTRL_CS];
			end else if (wa == mpd_pkg::OFS_IRQ_MASK) begin
				s_nxt.irq_mask = hwdata_i[mpd_pkg::IRQ_W-1:0];
			end else if (wa == mpd_pkg::OFS_IVL) begin
				s_nxt.ivl = hwdata_i[mpd_pkg::IVL_W-1:0];
			end else if (wa >= mpd_pkg::OFS_CFG && ci < IW'(N)
				&& wa < mpd_pkg::OFS_CFG + 12'(N * 4)) begin
				// upper bound stops high addresses aliasing low instances
				s_nxt.cfg[ci] = hwdata_i[CW-1:0];
			end
		end

		// address phase: decode and prepare read data one cycle early
		a = {haddr_i[11:2], 2'h0};
		act64 = 64'(s_r.active);
		rd = '0;
		if (a == mpd_pkg::OFS_CTRL) begin
			rd[mpd_pkg::CTRL_RUN] = s_r.run;
			rd[mpd_pkg::CTRL_CS] = s_r.cs_flag;
		end else if (a == mpd_pkg::OFS_STATUS) begin
			rd[IW-1:0] = s_r.shown;
			rd[mpd_pkg::STAT_VALID] = s_r.shown_v;
		end else if (a == mpd_pkg::OFS_IRQ_STAT) begin
			rd[mpd_pkg::IRQ_W-1:0] = s_r.irq_stat;
		end else if (a == mpd_pkg::OFS_IRQ_MASK) begin
			rd[mpd_pkg::IRQ_W-1:0] = s_r.irq_mask;
		end else if (a == mpd_pkg::OFS_IVL) begin
			rd[mpd_pkg::IVL_W-1:0] = s_r.ivl;
		end else if (a == mpd_pkg::OFS_ACT_LO) begin
			rd = act64[31:0];
		end else if (a == mpd_pkg::OFS_ACT_HI) begin
			rd = act64[63:32];
		end else if (a >= mpd_pkg::OFS_CFG
			&& IW'((a - mpd_pkg::OFS_CFG) >> 2) < IW'(N)
			&& a < mpd_pkg::OFS_CFG + 12'(N * 4)) begin
			rd[CW-1:0] = s_r.cfg[IW'((a - mpd_pkg::OFS_CFG) >> 2)];
		end
		s_nxt.wr_pend = 1'b0;
		if (hsel_i && htrans_i[1] && hready_i) begin
			s_nxt.wr_pend = hwrite_i;
			s_nxt.wr_addr = a;
			s_nxt.rdata = hwrite_i ? s_r.rdata : rd;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_r <= '0;
			s_r.ivl <= mpd_pkg::IVL_RST;
			s_r.cfg <= {N{mpd_pkg::CFG_RST}};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// zero wait states, so the slave never stalls or errors
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign hrdata_o = s_r.rdata;
	assign msg_active_o = s_r.active;
	assign shown_valid_o = s_r.shown_v;
	assign shown_index_o = s_r.shown;
	// routing is gated by the valid flag so idle panels stay blank
	assign builtin_display_target_o = s_r.shown_v
		&& sc[mpd_pkg::CFG_BUILTIN];
	assign external_panel_target_o = s_r.shown_v
		&& sc[mpd_pkg::CFG_EXTERN];
	assign web_show_o = s_r.shown_v && sc[mpd_pkg::CFG_WEB];
	assign scroll_style_o = sc[mpd_pkg::CFG_STYLE];
	assign line_scroll_enable_o = s_r.shown_v
		? sc[mpd_pkg::CFG_LINE +: mpd_pkg::LINES] : '0;
	// scroll counters keep running when idle, so gate with the valid flag
	assign char_step_o = s_r.shown_v && s_r.step
		&& !sc[mpd_pkg::CFG_STYLE];
	assign half_select_o = s_r.shown_v && s_r.half
		&& sc[mpd_pkg::CFG_STYLE];
	assign irq_o = |(s_r.irq_stat & s_r.irq_mask);
endmodule // mpd_arbiter
`default_nettype wire

// [bench/mpd_monitor.sv]
// Purpose: port-level checks on the message arbiter
// Assumes: one clock domain, asynchronous active-low reset
// Notes: instance 0 stands for all instances to keep this small
`timescale 1ns/10ps
`default_nettype none
module mpd_monitor #(
	parameter int NUM_MSGS = 50
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	// instances
	input wire logic [NUM_MSGS-1:0] msg_enable_i,
	input wire logic [NUM_MSGS-1:0] msg_active_o,
	// display selection
	input wire logic shown_valid_o,
	input wire logic [mpd_pkg::IDX_W-1:0] shown_index_o,
	input wire logic scroll_style_o,
	input wire logic [mpd_pkg::LINES-1:0] line_scroll_enable_o,
	input wire logic char_step_o
);
	// -----
	// sequences; enables pass a two-flop sync first
	// -----
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	sequence s_en_rise;
		$rose(msg_enable_i[0]);
	endsequence
	sequence s_en_held;
		msg_enable_i[0] [*6];
	endsequence
	sequence s_quiet;
		!char_step_o [*3];
	endsequence
	AST_ACT_CAUSE: assert property ($rose(msg_active_o[0]) |->
		$past(msg_enable_i[0], 2)) else $error("active without enable");
	AST_ACT_SOON: assert property (s_en_rise |->
		##[1:4] msg_active_o[0]) else $error("activation late");
	AST_ACT_FALL: assert property ($fell(msg_active_o[0]) |->
		!$past(msg_enable_i[0], 2)) else $error("cleared while enabled");
	AST_ACT_HOLD: assert property (s_en_held |->
		msg_active_o[0]) else $error("active dropped while enabled");
	AST_SHOWN_LIVE: assert property (shown_valid_o |->
		shown_index_o < NUM_MSGS && msg_active_o[shown_index_o])
		else $error("shown message not active");
	AST_LINES_IDLE: assert property (!shown_valid_o |->
		line_scroll_enable_o == 6'h00) else $error("lines without message");
	AST_STEP_STYLE: assert property (char_step_o |->
		shown_valid_o && !scroll_style_o) else $error("step in wrong style");
	AST_STEP_GAP: assert property (char_step_o |=>
		s_quiet) else $error("steps too close");
endmodule // mpd_monitor
`default_nettype wire

// [bench/mpd_keypad.sv]
// Purpose: operator keypad model for the arbiter
// Assumes: sel 0 confirm, 1 up, 2 down
// Notes: key held 3 cycles then released 3, like a real press
`timescale 1ns/10ps
`default_nettype none
module mpd_keypad (
	// clock
	input wire logic sys_clk_i,
	// press request
	input wire logic [1:0] key_sel_i,
	input wire logic press_i,
	// key pins
	output logic confirm_o,
	output logic up_o,
	output logic down_o
);
	typedef struct packed {
		logic [2:0] cnt;
		logic [1:0] sel;
	} mpd_key_state_type;
	mpd_key_state_type k_r = '0;
	mpd_key_state_type k_nxt;
	// -----
	// press timer; release gap keeps one edge per press
	// -----
	always_comb begin
		k_nxt = k_r;
		if (press_i) begin
			k_nxt.cnt = 3'h6;
			k_nxt.sel = key_sel_i;
		end else if (k_r.cnt != 3'h0) begin
			k_nxt.cnt = k_r.cnt - 3'h1;
		end
	end
	// state register
	always_ff @(posedge sys_clk_i) begin
		k_r <= k_nxt;
	end
	assign confirm_o = k_r.cnt > 3'h3 && k_r.sel == 2'h0;
	assign up_o = k_r.cnt > 3'h3 && k_r.sel == 2'h1;
	assign down_o = k_r.cnt > 3'h3 && k_r.sel == 2'h2;
endmodule // mpd_keypad
`default_nettype wire

// [bench/message_priority_display_test.sv]
// Purpose: self-checking bench for the message arbiter
// Assumes: latencies of 3-4 edges on enables and keys
// Notes: tick cut to 4 cycles so scrolling stays short
`timescale 1ns/10ps
`default_nettype none
module message_priority_display_test;
	// -----
	// wiring
	// -----
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hrdy;
	logic [49:0] enab = 50'h0;
	logic [49:0] act;
	logic [1:0] ksel = 2'h0;
	logic kpress = 1'b0;
	logic ck, ku, kd, sv, bt, et, web, sty, stp, irq, hresp, half_sel;
	logic [5:0] si, lse;
	int err_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int n;
	mpd_arbiter #(.NUM_MSGS(50), .TICK_CYCLES(4)) dut (.sys_clk_i(sys_clk),
		.rst_b_i(rst_b), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
		.hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
		.msg_enable_i(enab), .msg_active_o(act), .confirm_key_i(ck),
		.up_key_i(ku), .down_key_i(kd), .shown_valid_o(sv),
		.shown_index_o(si), .builtin_display_target_o(bt),
		.external_panel_target_o(et), .web_show_o(web),
		.scroll_style_o(sty), .line_scroll_enable_o(lse),
		.char_step_o(stp), .half_select_o(half_sel), .irq_o(irq));
	mpd_keypad u_keys (.sys_clk_i(sys_clk), .key_sel_i(ksel),
		.press_i(kpress), .confirm_o(ck), .up_o(ku), .down_o(kd));
	// clock and hang guard
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			stop_test();
		end
	end
	// -----
	// shared tasks
	// -----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		if (err_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// one single transfer; entered just after a rising edge
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		haddr <= {20'h00000, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge sys_clk);
		while (!hrdy) @(posedge sys_clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge sys_clk);
		while (!hrdy) @(posedge sys_clk);
		q = hrdata;
	endtask
	// writes wait for the effect and the registered irq to land
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
		repeat (3) @(posedge sys_clk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
		chk({31'h0, hresp}, 32'h0);
	endtask
	task automatic en(input int i, input logic v);
		enab[i] <= v;
		repeat (6) @(posedge sys_clk);
	endtask
	task automatic key(input logic [1:0] s);
		ksel <= s;
		kpress <= 1'b1;
		@(posedge sys_clk);
		kpress <= 1'b0;
		repeat (10) @(posedge sys_clk);
	endtask
	task automatic shw(input logic v, input logic [5:0] ix);
		chk({25'h0, sv, v ? si : 6'h00}, {25'h0, v, ix});
	endtask
	// -----
	// scenarios
	// -----
	task automatic t_regs();
		rd(mpd_pkg::OFS_CFG, 32'h00000300);
		rd(mpd_pkg::OFS_IVL, 32'h00000064);
		rd(mpd_pkg::OFS_CTRL, 32'h0);
		rd(12'h020, 32'h0);
		rd(12'h1C8, 32'h0);
		// a write past the last instance must not alias instance 0
		wr(12'h200, 32'h0000007F);
		rd(mpd_pkg::OFS_CFG, 32'h00000300);
	endtask
	task automatic t_run();
		en(0, 1'b1);
		chk({31'h0, act[0]}, 32'h1);
		shw(1'b0, 6'h00);
		wr(mpd_pkg::OFS_CTRL, 32'h1);
		shw(1'b1, 6'h00);
		en(0, 1'b0);
		shw(1'b0, 6'h00);
	endtask
	task automatic t_prio();
		wr(12'h100, 32'h0003F105);
		wr(12'h104, 32'h00000209);
		wr(12'h10C, 32'h00000105);
		wr(mpd_pkg::OFS_IVL, 32'h1);
		en(0, 1'b1);
		shw(1'b1, 6'h00);
		chk({26'h0, lse}, 32'h3F);
		chk({30'h0, bt, et}, 32'h2);
		n = 0;
		repeat (40) begin
			@(negedge sys_clk);
			if (stp === 1'b1) n++;
		end
		@(posedge sys_clk);
		chk(n, 10);
		en(3, 1'b1);
		shw(1'b1, 6'h00);
		en(1, 1'b1);
		shw(1'b1, 6'h01);
		chk({30'h0, bt, et}, 32'h1);
		rd(mpd_pkg::OFS_STATUS, 32'h00000101);
		rd(mpd_pkg::OFS_ACT_LO, 32'h0000000B);
		rd(mpd_pkg::OFS_ACT_HI, 32'h0);
		key(2'h1);
		shw(1'b1, 6'h03);
		key(2'h2);
		shw(1'b1, 6'h01);
		en(1, 1'b0);
		chk({31'h0, act[1]}, 32'h0);
		shw(1'b1, 6'h00);
		en(0, 1'b0);
		en(3, 1'b0);
	endtask
	// ack message with irq raised, masked and cleared
	task automatic t_ack();
		wr(12'h108, 32'h000001FF);
		wr(mpd_pkg::OFS_IRQ_STAT, 32'h7);
		wr(mpd_pkg::OFS_IRQ_MASK, 32'h7);
		en(2, 1'b1);
		shw(1'b1, 6'h02);
		chk({31'h0, irq}, 32'h1);
		rd(mpd_pkg::OFS_IRQ_STAT, 32'h3);
		key(2'h0);
		chk({31'h0, act[2]}, 32'h1);
		en(2, 1'b0);
		shw(1'b1, 6'h02);
		key(2'h0);
		chk({31'h0, act[2]}, 32'h0);
		shw(1'b0, 6'h00);
		rd(mpd_pkg::OFS_IRQ_STAT, 32'h7);
		wr(mpd_pkg::OFS_IRQ_MASK, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(mpd_pkg::OFS_IRQ_MASK, 32'h7);
		wr(mpd_pkg::OFS_IRQ_STAT, 32'h7);
		chk({31'h0, irq}, 32'h0);
	endtask
	task automatic t_cs();
		wr(12'h110, 32'h00040D01);
		en(4, 1'b1);
		shw(1'b0, 6'h00);
		wr(mpd_pkg::OFS_CTRL, 32'h3);
		shw(1'b1, 6'h04);
		chk({31'h0, web}, 32'h1);
		chk({29'h0, sty, stp, half_sel}, 32'h4);
		// ten steps of four cycles each flip the half once
		repeat (40) @(posedge sys_clk);
		chk({31'h0, half_sel}, 32'h1);
		en(4, 1'b0);
	endtask
	// main sequence
	initial begin
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		t_regs();
		t_run();
		t_prio();
		t_ack();
		t_cs();
		stop_test();
	end
endmodule // message_priority_display_test
bind mpd_arbiter mpd_monitor #(.NUM_MSGS(NUM_MSGS)) u_mon (.sys_clk_i,
	.rst_b_i, .msg_enable_i, .msg_active_o, .shown_valid_o, .shown_index_o,
	.scroll_style_o, .line_scroll_enable_o, .char_step_o);
`default_nettype wire
